// [hw/d3sm_monitor.sv]
// DS3 receive overhead status monitor with AHB-Lite registers
`timescale 1ns/1ns
`include "d3sm_regs.svh"
module d3sm_monitor (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Framer side
  input wire logic mf_end,
  input wire logic frame_unaligned_flag,
  input wire d3sm_pkg::d3sm_ovh_t ovh,
  input wire d3sm_pkg::d3sm_err_t errs,
  input wire logic one_sec_tick,
  input wire logic spare_link_tx_pending,
  input wire logic [6:0] loop_code_status_reg,
  // Interrupt
  output logic irq
);
  import d3sm_pkg::*;

  logic [31:0] hrdata_r;
  logic wr_int_r, wr_mask_r, wr_ctrl_r;
  logic [15:0] int_stat_r, int_mask_r, ctrl_r, stat_prev_r;
  logic [15:0] stat_w, rdv, evt, lvl, wclr;
  logic acc, rd_stat, cbit, aligned, aps;
  logic [7:0] thr;
  logic txe_r, lpc_chg_r, sec_r, ident_chg_r, last_aic_r;
  logic [6:0] lc_prev_r;
  logic nr_img_r, aic_img_r, x_img_r;
  d3sm_pers_t p_nr_r, p_aic_r, p_x_r, p_nr_nxt, p_aic_nxt, p_x_nxt;
  logic [3:0] idle_ecnt_r, ais_ecnt_r, idle_ecnt_nxt, ais_ecnt_nxt;
  logic ais_err, idle_act, ais_act;
  logic [7:0] idle_int_r, ais_int_r, idle_int_nxt, ais_int_nxt;
  logic idle_state_r, ais_state_r;

  // Persistence step on one sample
  function automatic d3sm_pers_t d3sm_persist(d3sm_pers_t p, logic s);
    d3sm_pers_t n;
    n = p;
    if (s != p.cand || p.cnt == 2'h0) begin
      n.cand = s;
      n.cnt = 2'h1;
    end else if (p.cnt != `D3SM_PERSIST) begin
      n.cnt = p.cnt + 2'h1;
    end
    return n;
  endfunction

  // Saturating error count
  function automatic logic [3:0] d3sm_sat(logic [3:0] c, logic inc);
    return (c == `D3SM_ERR_LIMIT) ? c : c + {3'h0, inc};
  endfunction

  // Saturating integrator bounded by threshold
  function automatic logic [7:0] d3sm_integ(logic [7:0] c, logic up, logic [7:0] t);
    if (up) begin
      return (c >= t) ? t : c + 8'h01;
    end
    return (c == 8'h00) ? 8'h00 : c - 8'h01;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign acc = hsel && htrans[1] && hready;
  assign rd_stat = acc && !hwrite && haddr == `D3SM_OFS_STATUS;

  // Read mux, unmapped reads zero
  always_comb begin
    if (haddr == `D3SM_OFS_STATUS) begin
      rdv = stat_w;
    end else if (haddr == `D3SM_OFS_INT_STAT) begin
      rdv = int_stat_r;
    end else if (haddr == `D3SM_OFS_INT_MASK) begin
      rdv = int_mask_r;
    end else if (haddr == `D3SM_OFS_CTRL) begin
      rdv = ctrl_r;
    end else begin
      rdv = 16'h0000;
    end
  end

  // Read data captured at address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (acc && !hwrite) begin
      hrdata_r <= {16'h0000, rdv};
    end
  end

  // Write targets held for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_int_r <= 1'b0;
      wr_mask_r <= 1'b0;
      wr_ctrl_r <= 1'b0;
    end else begin
      wr_int_r <= acc && hwrite && haddr == `D3SM_OFS_INT_STAT;
      wr_mask_r <= acc && hwrite && haddr == `D3SM_OFS_INT_MASK;
      wr_ctrl_r <= acc && hwrite && haddr == `D3SM_OFS_CTRL;
    end
  end

  // Mask and control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_mask_r <= `D3SM_MASK_RST;
      ctrl_r <= `D3SM_CTRL_RST;
    end else begin
      if (wr_mask_r) begin
        int_mask_r <= hwdata[15:0];
      end
      if (wr_ctrl_r) begin
        ctrl_r <= hwdata[15:0];
      end
    end
  end

  assign thr = ctrl_r[`D3SM_THR_HI:`D3SM_THR_LO];
  assign cbit = ctrl_r[`D3SM_B_CBIT];
  assign aps = ctrl_r[`D3SM_B_APS];
  assign aligned = !frame_unaligned_flag;

  ////////////////////////////////////////////////////////////////////////
  // Simple status conditions

  // Spare buffer empty level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txe_r <= 1'b0;
    end else begin
      txe_r <= !spare_link_tx_pending; // [R1]
    end
  end

  // Loop code change, cleared by status read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lc_prev_r <= 7'h00;
      lpc_chg_r <= 1'b0;
    end else begin
      lc_prev_r <= loop_code_status_reg;
      if (loop_code_status_reg != lc_prev_r) begin
        lpc_chg_r <= 1'b1; // [R2]
      end else if (rd_stat) begin
        lpc_chg_r <= 1'b0;
      end
    end
  end

  // One-second toggle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sec_r <= 1'b0;
    end else if (one_sec_tick) begin
      sec_r <= !sec_r; // [R3]
    end
  end

  // Ident bit change in M13 mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_aic_r <= 1'b0;
      ident_chg_r <= 1'b0;
    end else begin
      if (mf_end) begin
        last_aic_r <= ovh.ident_bit_image;
      end
      if (mf_end && !cbit && ovh.ident_bit_image != last_aic_r) begin
        ident_chg_r <= 1'b1; // [R6]
      end else if (rd_stat) begin
        ident_chg_r <= 1'b0; // [R15]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Overhead image filters

  always_comb begin
    p_nr_nxt = aligned && cbit ? d3sm_persist(p_nr_r, ovh.nr) : '0; // [R4]
    p_aic_nxt = aligned ? d3sm_persist(p_aic_r, ovh.ident_bit_image) : '0; // [R5]
    p_x_nxt = aligned && ovh.x1 == ovh.x2 ? d3sm_persist(p_x_r, ovh.x1) : '0; // [R7]
  end

  // Images follow three agreeing multiframes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      p_nr_r <= '0;
      p_aic_r <= '0;
      p_x_r <= '0;
      nr_img_r <= 1'b0;
      aic_img_r <= 1'b0;
      x_img_r <= 1'b0;
    end else if (mf_end) begin
      p_nr_r <= p_nr_nxt;
      p_aic_r <= p_aic_nxt;
      p_x_r <= p_x_nxt;
      if (p_nr_nxt.cnt == `D3SM_PERSIST) begin
        nr_img_r <= p_nr_nxt.cand; // [R4]
      end
      if (p_aic_nxt.cnt == `D3SM_PERSIST) begin
        aic_img_r <= p_aic_nxt.cand; // [R5]
      end
      if (p_x_nxt.cnt == `D3SM_PERSIST) begin
        x_img_r <= p_x_nxt.cand; // [R7]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Idle and AIS detection

  assign ais_err = aps ? errs.ais_ones_err : errs.ais_framed_err; // [R10]
  assign idle_ecnt_nxt = d3sm_sat(idle_ecnt_r, errs.idle_err);
  assign ais_ecnt_nxt = d3sm_sat(ais_ecnt_r, ais_err);
  assign idle_act = idle_ecnt_nxt < `D3SM_ERR_LIMIT && aligned; // [R9]
  assign ais_act = ais_ecnt_nxt < `D3SM_ERR_LIMIT && (aps || aligned); // [R11]
  assign idle_int_nxt = d3sm_integ(idle_int_r, idle_act, thr); // [R12]
  assign ais_int_nxt = d3sm_integ(ais_int_r, ais_act, thr); // [R12]

  // Per-multiframe error counts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_ecnt_r <= 4'h0;
      ais_ecnt_r <= 4'h0;
    end else if (mf_end) begin
      idle_ecnt_r <= 4'h0;
      ais_ecnt_r <= 4'h0;
    end else begin
      idle_ecnt_r <= idle_ecnt_nxt;
      ais_ecnt_r <= ais_ecnt_nxt;
    end
  end

  // Integrators and declared states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_int_r <= 8'h00;
      ais_int_r <= 8'h00;
      idle_state_r <= 1'b0;
      ais_state_r <= 1'b0;
    end else if (mf_end) begin
      idle_int_r <= idle_int_nxt;
      ais_int_r <= ais_int_nxt;
      if (idle_act && idle_int_nxt >= thr) begin
        idle_state_r <= 1'b1; // [R8]
      end else if (!idle_act && idle_int_nxt == 8'h00) begin
        idle_state_r <= 1'b0;
      end
      if (ais_act && ais_int_nxt >= thr) begin
        ais_state_r <= 1'b1; // [R11]
      end else if (!ais_act && ais_int_nxt == 8'h00) begin
        ais_state_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status word and interrupts

  // Current conditions as status bits
  always_comb begin
    stat_w = 16'h0000;
    stat_w[`D3SM_B_FAS] = frame_unaligned_flag; // [R14]
    stat_w[`D3SM_B_AIS] = ais_state_r; // [R13]
    stat_w[`D3SM_B_IDLE] = idle_state_r; // [R13]
    stat_w[`D3SM_B_XIMG] = x_img_r;
    stat_w[`D3SM_B_AIC] = aic_img_r;
    stat_w[`D3SM_B_NR] = cbit ? nr_img_r : ident_chg_r;
    stat_w[`D3SM_B_SEC] = sec_r;
    stat_w[`D3SM_B_LPC] = lpc_chg_r;
    stat_w[`D3SM_B_TXE] = txe_r;
  end

  // Level bits raise on any edge, flags only on set
  always_comb begin
    lvl = 16'hffff;
    lvl[`D3SM_B_LPC] = 1'b0;
    lvl[`D3SM_B_NR] = cbit;
    evt = (stat_w ^ stat_prev_r) & (stat_w | lvl);
    wclr = wr_int_r ? hwdata[15:0] : 16'h0000;
  end

  // Sticky status, set wins over write-one clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_prev_r <= 16'h0000;
      int_stat_r <= 16'h0000;
    end else begin
      stat_prev_r <= stat_w;
      int_stat_r <= (int_stat_r & ~wclr) | evt;
    end
  end

  assign irq = |(int_stat_r & int_mask_r);

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence quiet_mf;
    mf_end && aligned && idle_ecnt_r == 4'h0 && !errs.idle_err;
  endsequence

  sequence pending_twice;
    spare_link_tx_pending ##1 spare_link_tx_pending;
  endsequence

  sec_toggle_a: assert property (one_sec_tick |=> sec_r != $past(sec_r)) // [R3]
    else $error("seconds bit did not toggle");
  tx_empty_a: assert property (pending_twice |-> !stat_w[`D3SM_B_TXE]) // [R1]
    else $error("empty bit set while buffer pending");
  loop_chg_a: assert property ((loop_code_status_reg != lc_prev_r) |=> lpc_chg_r) // [R2]
    else $error("loop code change not flagged");
  ident_chg_a: assert property ((mf_end && !cbit && ovh.ident_bit_image != last_aic_r) |=> ident_chg_r) // [R6]
    else $error("ident change not flagged");
  read_clear_a: assert property ((rd_stat && !(mf_end && !cbit)) |=> !ident_chg_r) // [R15]
    else $error("status read left ident flag set");
  nr_hold_a: assert property (!mf_end |=> $stable(nr_img_r) && $stable(aic_img_r)) // [R4]
    else $error("image changed outside multiframe end");
  aic_unaligned_a: assert property ((mf_end && !aligned) // [R5]
    |=> $stable(aic_img_r) && p_aic_r.cnt == 2'h0)
    else $error("ident image moved while unaligned");
  x_agree_a: assert property ((mf_end && ovh.x1 != ovh.x2) |=> $stable(x_img_r)) // [R7]
    else $error("x image moved on disagreeing bits");
  idle_up_a: assert property ((quiet_mf ##0 (idle_int_r < thr)) // [R9]
    |=> idle_int_r == $past(idle_int_r) + 8'h01)
    else $error("quiet multiframe did not raise idle integrator");
  idle_down_a: assert property ((mf_end && !aligned && idle_int_r != 8'h00) // [R12]
    |=> idle_int_r == $past(idle_int_r) - 8'h01)
    else $error("unaligned multiframe did not lower idle integrator");
  idle_rise_a: assert property ($rose(idle_state_r) |-> $past(mf_end) && idle_int_r >= thr) // [R8]
    else $error("idle declared before threshold");
  ais_fall_a: assert property ($fell(ais_state_r) |-> $past(mf_end) && ais_int_r == 8'h00) // [R11]
    else $error("ais cleared before integrator empty");
endmodule

// [hw/d3sm_regs.svh]
// Register offsets, field positions and counts of the receive status monitor
// How it works
// [R1] Transmit-empty bit set while spare buffer empty
// [R2] Loop-code-change bit set when loop code changes
// [R3] Seconds bit toggles on every one-second tick
// [R4] Network bit image: three aligned agreeing multiframes in C-bit mode
// [R5] Ident bit image: three aligned agreeing multiframes
// [R6] M13 mode: ident bit change sets changed flag
// [R7] X image needs both X bits equal, three times
// [R8] Idle declared after integration reaches timing threshold
// [R9] Idle multiframe active below fifteen pattern errors
// [R10] AIS form chosen: framed 1010 or unframed ones
// [R11] AIS active below fifteen errors, then integrated
// [R12] Integrator steps per multiframe, lost alignment lowers it except AIS in unframed-ones mode
// [R13] Status bit reads one while condition holds
// [R14] Alignment bit reads one when framer unaligned
// [R15] Status read clears the ident-changed flag
`ifndef D3SM_REGS_SVH
`define D3SM_REGS_SVH
`define D3SM_OFS_STATUS 32'h0000_0000
`define D3SM_OFS_INT_STAT 32'h0000_0004
`define D3SM_OFS_INT_MASK 32'h0000_0008
`define D3SM_OFS_CTRL 32'h0000_000c
`define D3SM_B_FAS 0
`define D3SM_B_AIS 4
`define D3SM_B_IDLE 5
`define D3SM_B_XIMG 6
`define D3SM_B_AIC 7
`define D3SM_B_NR 8
`define D3SM_B_SEC 9
`define D3SM_B_LPC 10
`define D3SM_B_TXE 11
`define D3SM_B_APS 0
`define D3SM_B_CBIT 1
`define D3SM_THR_HI 15
`define D3SM_THR_LO 8
`define D3SM_CTRL_RST 16'h0a00
`define D3SM_MASK_RST 16'h0000
`define D3SM_ERR_LIMIT 4'hf
`define D3SM_PERSIST 2'h3
`endif

// [hw/d3sm_pkg.sv]
// Types shared by the receive status monitor
package d3sm_pkg;
  // Overhead bits sampled once per multiframe
  typedef struct packed {
    logic x1;
    logic x2;
    logic ident_bit_image;
    logic nr;
  } d3sm_ovh_t;
  // Pattern error strobes, one pulse per bit error
  typedef struct packed {
    logic idle_err;
    logic ais_framed_err;
    logic ais_ones_err;
  } d3sm_err_t;
  // Persistence filter state
  typedef struct packed {
    logic cand;
    logic [1:0] cnt;
  } d3sm_pers_t;
endpackage

// [test/d3sm_line_model.sv]
// Framer-side model: multiframe strobes, overhead bits and error pulses
`timescale 1ns/1ns
module d3sm_line_model (
  // Clock
  input wire logic hclk,
  // Framer outputs
  output logic mf_end,
  output logic frame_unaligned_flag,
  output d3sm_pkg::d3sm_ovh_t ovh,
  output d3sm_pkg::d3sm_err_t errs
);
  import d3sm_pkg::*;
  // Idle line: unaligned, no strobes
  initial begin
    mf_end = 1'b0;
    frame_unaligned_flag = 1'b1;
    ovh = '0;
    errs = '0;
  end
  // One multiframe: error pulses, then end strobe with its overhead bits
  task automatic send_mf(input logic [3:0] o, input logic u, input int ni, input int nf,
                         input int nu);
    int i;
    @(posedge hclk);
    frame_unaligned_flag <= u;
    for (i = 0; i < 15; i++) begin
      errs <= {i < ni, i < nf, i < nu};
      @(posedge hclk);
    end
    errs <= '0;
    mf_end <= 1'b1;
    ovh <= d3sm_ovh_t'(o);
    @(posedge hclk);
    mf_end <= 1'b0;
  endtask
endmodule

// [test/d3sm_monitor_bench.sv]
// Self-checking bench of the DS3 receive status monitor
`timescale 1ns/1ns
`include "d3sm_regs.svh"
module d3sm_monitor_bench;
  import d3sm_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic hreadyout, hresp, irq, mf_end, frame_unaligned_flag;
  logic [31:0] hrdata;
  d3sm_ovh_t ovh;
  d3sm_err_t errs;
  logic one_sec_tick = 1'b0;
  logic spare_link_tx_pending = 1'b0;
  logic [6:0] loop_code_status_reg = '0;
  int failures = 0;
  int cmp_count = 0;
  logic [31:0] s;
  logic s0;

  // Clock, 20 ns period
  always #10 hclk = ~hclk;

  d3sm_monitor dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mf_end(mf_end),
    .frame_unaligned_flag(frame_unaligned_flag), .ovh(ovh), .errs(errs),
    .one_sec_tick(one_sec_tick), .spare_link_tx_pending(spare_link_tx_pending),
    .loop_code_status_reg(loop_code_status_reg), .irq(irq));
  d3sm_line_model line (.hclk(hclk), .mf_end(mf_end),
    .frame_unaligned_flag(frame_unaligned_flag), .ovh(ovh), .errs(errs));

  ////////////////////////////////////////////////////////////////////////////////
  // Compare and report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic chkb(input int b, input logic e);
    chk({31'h0, s[b]}, {31'h0, e});
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Wait for hready high at a rising edge, bounded
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
  endtask
  // One single word transfer: address phase, then data phase
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    d = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] wd);
    logic [31:0] d;
    xfer(1'b1, a, wd, d);
  endtask
  task automatic stat;
    xfer(1'b0, `D3SM_OFS_STATUS, 32'h0, s);
  endtask
  // Interrupt line looked at mid-cycle, once settled
  task automatic irqchk(input logic e);
    @(negedge hclk);
    chk({31'h0, irq}, {31'h0, e});
    @(posedge hclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    xfer(1'b0, `D3SM_OFS_CTRL, 32'h0, s);
    chk(s, {16'h0, `D3SM_CTRL_RST});
    chk({31'h0, hresp}, 32'h0);
    xfer(1'b0, 32'h0000_0010, 32'h0, s);
    chk(s, 32'h0);
    stat();
    chkb(`D3SM_B_FAS, 1'b1);
    chkb(`D3SM_B_TXE, 1'b1);
    $display("test reset done");
  endtask
  task automatic t_txe_irq;
    wr(`D3SM_OFS_INT_STAT, 32'h0000_ffff);
    spare_link_tx_pending <= 1'b1;
    @(posedge hclk);
    stat();
    chkb(`D3SM_B_TXE, 1'b0);
    xfer(1'b0, `D3SM_OFS_INT_STAT, 32'h0, s);
    chkb(`D3SM_B_TXE, 1'b1);
    irqchk(1'b0);
    wr(`D3SM_OFS_INT_MASK, 32'h0000_0800);
    irqchk(1'b1);
    wr(`D3SM_OFS_INT_STAT, 32'h0000_0800);
    irqchk(1'b0);
    $display("test txe_irq done");
  endtask
  task automatic t_lpc_sec;
    loop_code_status_reg <= 7'h05;
    @(posedge hclk);
    stat();
    chkb(`D3SM_B_LPC, 1'b1);
    s0 = s[`D3SM_B_SEC];
    one_sec_tick <= 1'b1;
    @(posedge hclk);
    one_sec_tick <= 1'b0;
    stat();
    chkb(`D3SM_B_SEC, ~s0);
    $display("test lpc_sec done");
  endtask
  task automatic t_images;
    line.send_mf(4'b1000, 1'b0, 15, 15, 15);
    line.send_mf(4'b1000, 1'b0, 15, 15, 15);
    line.send_mf(4'b1100, 1'b0, 15, 15, 15);
    line.send_mf(4'b1100, 1'b0, 15, 15, 15);
    stat();
    chkb(`D3SM_B_FAS, 1'b0);
    chkb(`D3SM_B_XIMG, 1'b0);
    line.send_mf(4'b1100, 1'b0, 15, 15, 15);
    stat();
    chkb(`D3SM_B_XIMG, 1'b1);
    line.send_mf(4'b1110, 1'b0, 15, 15, 15);
    stat();
    chkb(`D3SM_B_NR, 1'b1);
    chkb(`D3SM_B_AIC, 1'b0);
    stat();
    chkb(`D3SM_B_NR, 1'b0);
    line.send_mf(4'b1110, 1'b1, 15, 15, 15);
    line.send_mf(4'b1110, 1'b0, 15, 15, 15);
    line.send_mf(4'b1110, 1'b0, 15, 15, 15);
    stat();
    chkb(`D3SM_B_AIC, 1'b0);
    line.send_mf(4'b1110, 1'b0, 15, 15, 15);
    stat();
    chkb(`D3SM_B_AIC, 1'b1);
    $display("test images done");
  endtask
  task automatic t_nr;
    wr(`D3SM_OFS_CTRL, 32'h0000_0202);
    line.send_mf(4'b1111, 1'b0, 15, 15, 15);
    line.send_mf(4'b1111, 1'b0, 15, 15, 15);
    stat();
    chkb(`D3SM_B_NR, 1'b0);
    line.send_mf(4'b1111, 1'b0, 15, 15, 15);
    stat();
    chkb(`D3SM_B_NR, 1'b1);
    $display("test nr done");
  endtask
  task automatic t_idle;
    line.send_mf(4'b1111, 1'b0, 0, 15, 15);
    stat();
    chkb(`D3SM_B_IDLE, 1'b0);
    line.send_mf(4'b1111, 1'b0, 14, 15, 15);
    stat();
    chkb(`D3SM_B_IDLE, 1'b1);
    line.send_mf(4'b1111, 1'b1, 15, 15, 15);
    stat();
    chkb(`D3SM_B_IDLE, 1'b1);
    line.send_mf(4'b1111, 1'b0, 15, 15, 15);
    stat();
    chkb(`D3SM_B_IDLE, 1'b0);
    $display("test idle done");
  endtask
  task automatic t_ais;
    line.send_mf(4'b1111, 1'b0, 15, 14, 15);
    line.send_mf(4'b1111, 1'b0, 15, 14, 15);
    stat();
    chkb(`D3SM_B_AIS, 1'b1);
    line.send_mf(4'b1111, 1'b0, 15, 15, 15);
    line.send_mf(4'b1111, 1'b0, 15, 15, 15);
    stat();
    chkb(`D3SM_B_AIS, 1'b0);
    wr(`D3SM_OFS_CTRL, 32'h0000_0203);
    line.send_mf(4'b0000, 1'b1, 15, 15, 0);
    line.send_mf(4'b0000, 1'b1, 15, 15, 0);
    stat();
    chkb(`D3SM_B_AIS, 1'b1);
    $display("test ais done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset for 6 cycles, then the scenarios
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_txe_irq();
    t_lpc_sec();
    t_images();
    t_nr();
    t_idle();
    t_ais();
    report_and_stop();
  end
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #400000;
    failures++;
    report_and_stop();
  end
endmodule
